// File: src/sfe_front_end.sv
`timescale 1ns/1ps
`include "sfe_params.svh"
// Contract
// - Invert bit complements protection; zeros protect none, or the whole array with invert set.
// - Erase/program touching protected area is discarded.
// - Chip select falling starts a frame.
// - First eight bits form the opcode.
// - Sample input on rising clock, MSB first.
// - Chip select rising ends frame; act then.
// - Reads may stop after any bit.
// - Writes need whole bytes before chip select rises.
// - While busy only status reads work, and suspend except during a status write.
// - 05h/35h stream status low/high byte repeatedly.
// - Returned bytes leave on lane 1, MSB first.
// - Decode 20h, 52h, D8h erases with address.
// - Decode 75h suspend, 7Ah resume, single byte.
// - Quad program: nibble per clock, lane bit mapping.
// - Return identity codes for AB/90/92/94/9F.
// - Write latch clears at reset and completion.
// - Lanes 2/3 carry data only with quad enable.
// - Invert bit swaps protected and unprotected regions.
module sfe_front_end import sfe_pkg::*; #(
   parameter logic [7:0] MFR_ID = 8'hA5, // Arbitrary value.
   parameter logic [7:0] DEV_ID = 8'h3C, // Arbitrary value.
   parameter logic [15:0] LONG_ID = 16'h5A17, // Arbitrary value.
   parameter logic [15:0] PROG_CYCLES = `SFE_PROG_CYC,
   parameter logic [15:0] ERASE_CYCLES = `SFE_ERASE_CYC,
   parameter logic [15:0] STAT_CYCLES = `SFE_STAT_CYC
) (
   input wire logic clk_sys, // System clock.
   input wire logic rstn, // Asynchronous reset, active low.
   input wire logic spiClk, // Link serial clock.
   input wire logic csN, // Chip select, active low.
   input wire logic lane0In, // Lane 0, serial_in.
   input wire logic lane1In, // Lane 1 input, quad program.
   output logic lane1Out, // Lane 1 output data.
   output logic lane1Oe, // Lane 1 drive enable.
   input wire logic lane2In, // Lane 2 or write-protect, active low.
   input wire logic lane3In, // Lane 3 input, quad program.
   output sfe_arr_cmd_type arrCmd, // Array command pulse.
   output sfe_byte_type pageByte, // Page data byte pulse.
   output logic [15:0] statusWord, // Status register view.
   output logic busy // Internal cycle in progress.
);
   function automatic logic sfeProtHit(input logic [15:0] cfg, input logic [23:0] lo,
                                       input logic [23:0] hi);
      logic [2:0] bp;
      logic [23:0] size;
      logic [23:0] pl;
      logic [23:0] ph;
      logic none;
      logic contained;
      logic overlap;
      bp = cfg[`SFE_SR_BP2:`SFE_SR_BP0];
      none = (bp == 3'h0);
      size = `SFE_SZ_ARRAY;
      if (cfg[`SFE_SR_SEC]) begin
         case (bp)
            3'h1: size = `SFE_SZ_4K;
            3'h2: size = `SFE_SZ_8K;
            3'h3: size = `SFE_SZ_16K;
            3'h4, 3'h5, 3'h6: size = `SFE_SZ_32K;
            default: size = `SFE_SZ_ARRAY;
         endcase
      end else begin
         case (bp)
            3'h1: size = `SFE_SZ_64K;
            3'h2: size = `SFE_SZ_128K;
            3'h3: size = `SFE_SZ_256K;
            default: size = `SFE_SZ_ARRAY;
         endcase
      end
      pl = cfg[`SFE_SR_TB] ? 24'h00_0000 : `SFE_SZ_ARRAY - size;
      ph = cfg[`SFE_SR_TB] ? size - 24'h00_0001 : `SFE_SZ_ARRAY - 24'h00_0001;
      contained = !none && lo >= pl && hi <= ph;
      overlap = !none && lo <= ph && hi >= pl;
      return cfg[`SFE_SR_CMP] ? !contained : overlap;
   endfunction

   // ---------------- Link domain ----------------
   // Capture registers reset only with rstn so they stay frozen after the frame
   // ends; the system side reads them once chip select has been synchronised.
   logic linkRstN;
   logic inFrame_q, inFrame_d;
   logic [19:0] bitCnt_q, bitCnt_d;
   logic [7:0] opcode_q, opcode_d;
   logic [23:0] addr_q, addr_d;
   logic [15:0] dataSr_q, dataSr_d;
   logic [7:0] dataByte_q, dataByte_d;
   logic dataTgl_q, dataTgl_d;
   logic frameTgl_q, frameTgl_d;
   logic [15:0] stL1_q, stL2_q;
   logic outBit_q, outBit_d, outOe_q, outOe_d;
   logic [19:0] cnt;
   logic quadData, dataPhase, isProg;
   logic [3:0] nibble;
   logic [16:0] byteIdx;
   logic [7:0] txByte;
   logic txValid;

   assign linkRstN = rstn & ~csN;

   always_comb begin
      cnt = inFrame_q ? bitCnt_q : 20'h0_0000;
      isProg = (opcode_q == `SFE_OP_PROG) || (opcode_q == `SFE_OP_QPROG);
      quadData = (opcode_q == `SFE_OP_QPROG) && stL2_q[`SFE_SR_QE] &&
                 (cnt >= `SFE_BITS_ADDR);
      dataPhase = (cnt >= `SFE_BITS_ADDR) ||
                  ((opcode_q == `SFE_OP_STAT_WR) && (cnt >= `SFE_BITS_OP));
      nibble = {lane3In, lane2In, lane1In, lane0In};
      inFrame_d = 1'b1;
      frameTgl_d = inFrame_q ? frameTgl_q : ~frameTgl_q;
      opcode_d = opcode_q;
      addr_d = addr_q;
      dataSr_d = dataSr_q;
      dataByte_d = dataByte_q;
      dataTgl_d = dataTgl_q;
      bitCnt_d = (cnt == 20'hF_FFF8) ? cnt : cnt + (quadData ? 20'h0_0004 : 20'h0_0001);
      if (cnt < `SFE_BITS_OP) begin
         opcode_d = {opcode_q[6:0], lane0In};
      end else if (!dataPhase) begin
         addr_d = {addr_q[22:0], lane0In};
      end else if (quadData) begin
         dataSr_d = {dataSr_q[11:0], nibble};
      end else begin
         dataSr_d = {dataSr_q[14:0], lane0In};
      end
      if (dataPhase && isProg && bitCnt_d[2:0] == 3'h0 && cnt >= `SFE_BITS_ADDR) begin
         dataByte_d = dataSr_d[7:0];
         dataTgl_d = ~dataTgl_q;
      end
   end

   always_ff @(posedge spiClk or negedge linkRstN) begin
      if (!linkRstN) begin
         inFrame_q <= 1'b0;
      end else begin
         inFrame_q <= inFrame_d;
      end
   end

   always_ff @(posedge spiClk or negedge rstn) begin
      if (!rstn) begin
         bitCnt_q <= 20'h0_0000;
         opcode_q <= 8'h00;
         addr_q <= 24'h00_0000;
         dataSr_q <= 16'h0000;
         dataByte_q <= 8'h00;
         dataTgl_q <= 1'b0;
         frameTgl_q <= 1'b0;
         stL1_q <= 16'h0000;
         stL2_q <= 16'h0000;
      end else begin
         bitCnt_q <= bitCnt_d;
         opcode_q <= opcode_d;
         addr_q <= addr_d;
         dataSr_q <= dataSr_d;
         dataByte_q <= dataByte_d;
         dataTgl_q <= dataTgl_d;
         frameTgl_q <= frameTgl_d;
         stL1_q <= statusWord;
         stL2_q <= stL1_q;
      end
   end

   // Status word crosses bit by bit; a cycle ending mid-frame can move the busy, write latch and configuration bits.
   always_comb begin
      byteIdx = bitCnt_q[19:3];
      txByte = 8'h00;
      txValid = 1'b0;
      if (bitCnt_q >= `SFE_BITS_OP) begin
         case (opcode_q)
            `SFE_OP_STAT_LO: begin
               txByte = stL2_q[7:0];
               txValid = 1'b1;
            end
            `SFE_OP_STAT_HI: begin
               txByte = stL2_q[15:8];
               txValid = 1'b1;
            end
            `SFE_OP_ID_LONG: begin
               txByte = (byteIdx == 17'h0_0001) ? MFR_ID :
                        (byteIdx == 17'h0_0002) ? LONG_ID[15:8] : LONG_ID[7:0];
               txValid = !stL2_q[0] && byteIdx <= 17'h0_0003;
            end
            `SFE_OP_ID_SHORT: begin
               txByte = DEV_ID;
               txValid = !stL2_q[0] && byteIdx >= 17'h0_0004;
            end
            `SFE_OP_ID_PAIR, `SFE_OP_ID_DUAL, `SFE_OP_ID_QUAD: begin
               txByte = byteIdx[0] ? DEV_ID : MFR_ID;
               txValid = !stL2_q[0] && byteIdx >= 17'h0_0004;
            end
            default: begin
               txValid = 1'b0;
            end
         endcase
      end
      outBit_d = txByte[~bitCnt_q[2:0]];
      outOe_d = txValid;
   end

   // Output changes on the falling edge so the host sees it stable on the rise.
   always_ff @(negedge spiClk or negedge linkRstN) begin
      if (!linkRstN) begin
         outBit_q <= 1'b0;
         outOe_q <= 1'b0;
      end else begin
         outBit_q <= outBit_d;
         outOe_q <= outOe_d;
      end
   end

   assign lane1Out = outBit_q;
   assign lane1Oe = outOe_q;

   // ---------------- System domain ----------------
   logic [3:0] syn1_q, syn2_q;
   logic csPrev_q, frameSeen_q, frameSeen_d, dataPrev_q;
   sfe_op_state_type opState_q, opState_d;
   sfe_arr_op_type curOp_q, curOp_d;
   logic [15:0] busyCnt_q, busyCnt_d;
   logic [15:0] cfg_q, cfg_d;
   logic wel_q, wel_d, volWr_q, volWr_d;
   // Captured when the write is accepted, because a status read during the write cycle
   // reuses the link capture registers.
   logic [15:0] pendCfg_q, pendCfg_d;
   sfe_arr_cmd_type arrCmd_d;
   sfe_byte_type pageByte_d;
   logic csRise, wrOk, srLocked, protHit;
   logic [23:0] lo, hi, span;
   sfe_arr_op_type eraseOp;
   logic [15:0] newCfg;

   always_comb begin
      csRise = syn2_q[0] && !csPrev_q;
      frameSeen_d = csRise ? syn2_q[1] : frameSeen_q;
      wrOk = bitCnt_q[2:0] == 3'h0 && bitCnt_q >= `SFE_BITS_OP;
      srLocked = cfg_q[`SFE_SR_SRP1] ||
                 (cfg_q[`SFE_SR_SRP0] && !syn2_q[3] && !cfg_q[`SFE_SR_QE]);
      case (opcode_q)
         `SFE_OP_ERASE_4K: begin
            span = `SFE_SZ_4K;
            eraseOp = aoErase4k;
         end
         `SFE_OP_ERASE_32K: begin
            span = `SFE_SZ_32K;
            eraseOp = aoErase32k;
         end
         `SFE_OP_ERASE_64K: begin
            span = `SFE_SZ_64K;
            eraseOp = aoErase64k;
         end
         `SFE_OP_CHIP_A, `SFE_OP_CHIP_B: begin
            span = `SFE_SZ_ARRAY;
            eraseOp = aoEraseChip;
         end
         default: begin
            span = `SFE_SZ_PAGE;
            eraseOp = aoProgram;
         end
      endcase
      lo = addr_q & (`SFE_SZ_ARRAY - 24'h00_0001) & ~(span - 24'h00_0001);
      hi = lo + span - 24'h00_0001;
      protHit = sfeProtHit(cfg_q, lo, hi);
      if (bitCnt_q >= 20'h0_0018) begin
         newCfg = {dataSr_q[7:0], dataSr_q[15:8]};
      end else begin
         newCfg = {cfg_q[15:8], dataSr_q[7:0]};
      end
      newCfg = (newCfg & `SFE_CFG_MASK) | (cfg_q & `SFE_LB_MASK);
      opState_d = opState_q;
      curOp_d = curOp_q;
      busyCnt_d = busyCnt_q;
      cfg_d = cfg_q;
      wel_d = wel_q;
      volWr_d = volWr_q;
      pendCfg_d = pendCfg_q;
      arrCmd_d = '{valid: 1'b0, op: aoNone, addr: lo};
      pageByte_d = '{valid: 1'b0, data: dataByte_q};
      if (opState_q == opBusy) begin
         if (busyCnt_q == 16'h0000) begin
            opState_d = opIdle;
            wel_d = 1'b0;
            if (curOp_q == aoWriteStatus) begin
               cfg_d = pendCfg_q;
            end
         end else begin
            busyCnt_d = busyCnt_q - 16'h0001;
         end
      end
      if (syn2_q[2] != dataPrev_q && opState_q == opIdle && wel_q) begin
         pageByte_d.valid = 1'b1;
      end
      if (csRise && syn2_q[1] != frameSeen_q && wrOk) begin
         if (opState_q == opBusy) begin
            if (opcode_q == `SFE_OP_SUSPEND && curOp_q != aoWriteStatus) begin
               opState_d = opSusp;
               busyCnt_d = busyCnt_q;
               arrCmd_d.valid = 1'b1;
               arrCmd_d.op = aoSuspend;
            end
         end else begin
            volWr_d = 1'b0;
            case (opcode_q)
               `SFE_OP_WR_EN: wel_d = 1'b1;
               `SFE_OP_WR_DIS: wel_d = 1'b0;
               `SFE_OP_VOL_EN: volWr_d = 1'b1;
               `SFE_OP_STAT_WR: begin
                  if ((wel_q || volWr_q) && !srLocked && bitCnt_q >= 20'h0_0010) begin
                     opState_d = opBusy;
                     curOp_d = aoWriteStatus;
                     busyCnt_d = STAT_CYCLES;
                     pendCfg_d = newCfg;
                  end
               end
               `SFE_OP_RESUME: begin
                  if (opState_q == opSusp) begin
                     opState_d = opBusy;
                     arrCmd_d.valid = 1'b1;
                     arrCmd_d.op = aoResume;
                  end
               end
               `SFE_OP_PROG, `SFE_OP_QPROG, `SFE_OP_ERASE_4K, `SFE_OP_ERASE_32K,
               `SFE_OP_ERASE_64K, `SFE_OP_CHIP_A, `SFE_OP_CHIP_B: begin
                  if (wel_q && !protHit && opState_q == opIdle &&
                      (bitCnt_q >= `SFE_BITS_ADDR || eraseOp == aoEraseChip)) begin
                     opState_d = opBusy;
                     curOp_d = eraseOp;
                     busyCnt_d = (eraseOp == aoProgram) ? PROG_CYCLES : ERASE_CYCLES;
                     arrCmd_d.valid = 1'b1;
                     arrCmd_d.op = eraseOp;
                  end
               end
               default: volWr_d = 1'b0;
            endcase
         end
      end
   end

   // Slot 0 chip select, 1 frame toggle, 2 data toggle, 3 write-protect pin.
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         syn1_q <= 4'h9;
         syn2_q <= 4'h9;
         csPrev_q <= 1'b1;
         frameSeen_q <= 1'b0;
         dataPrev_q <= 1'b0;
         opState_q <= opIdle;
         curOp_q <= aoNone;
         busyCnt_q <= 16'h0000;
         cfg_q <= `SFE_CFG_RESET;
         wel_q <= 1'b0;
         volWr_q <= 1'b0;
         pendCfg_q <= `SFE_CFG_RESET;
         arrCmd <= '{valid: 1'b0, op: aoNone, addr: 24'h00_0000};
         pageByte <= '{valid: 1'b0, data: 8'h00};
      end else begin
         syn1_q <= {lane2In, dataTgl_q, frameTgl_q, csN};
         syn2_q <= syn1_q;
         csPrev_q <= syn2_q[0];
         frameSeen_q <= frameSeen_d;
         dataPrev_q <= syn2_q[2];
         opState_q <= opState_d;
         curOp_q <= curOp_d;
         busyCnt_q <= busyCnt_d;
         cfg_q <= cfg_d;
         wel_q <= wel_d;
         volWr_q <= volWr_d;
         pendCfg_q <= pendCfg_d;
         arrCmd <= arrCmd_d;
         pageByte <= pageByte_d;
      end
   end

   assign busy = (opState_q == opBusy);
   assign statusWord = {opState_q == opSusp, cfg_q[14:2], wel_q, opState_q == opBusy};
endmodule

// File: src/sfe_params.svh
`ifndef SFE_PARAMS_SVH
`define SFE_PARAMS_SVH
`define SFE_OP_WR_EN 8'h06
`define SFE_OP_WR_DIS 8'h04
`define SFE_OP_VOL_EN 8'h50
`define SFE_OP_STAT_LO 8'h05
`define SFE_OP_STAT_HI 8'h35
`define SFE_OP_STAT_WR 8'h01
`define SFE_OP_PROG 8'h02
`define SFE_OP_QPROG 8'h32
`define SFE_OP_ERASE_4K 8'h20
`define SFE_OP_ERASE_32K 8'h52
`define SFE_OP_ERASE_64K 8'hD8
`define SFE_OP_CHIP_A 8'hC7
`define SFE_OP_CHIP_B 8'h60
`define SFE_OP_SUSPEND 8'h75
`define SFE_OP_RESUME 8'h7A
`define SFE_OP_ID_SHORT 8'hAB
`define SFE_OP_ID_PAIR 8'h90
`define SFE_OP_ID_DUAL 8'h92
`define SFE_OP_ID_QUAD 8'h94
`define SFE_OP_ID_LONG 8'h9F
`define SFE_SR_WEL 1
`define SFE_SR_BP0 2
`define SFE_SR_BP2 4
`define SFE_SR_TB 5
`define SFE_SR_SEC 6
`define SFE_SR_SRP0 7
`define SFE_SR_SRP1 8
`define SFE_SR_QE 9
`define SFE_SR_CMP 14
`define SFE_CFG_RESET 16'h0000
`define SFE_CFG_MASK 16'h7BFC
`define SFE_LB_MASK 16'h3800
`define SFE_SZ_ARRAY 24'h08_0000
`define SFE_SZ_4K 24'h00_1000
`define SFE_SZ_8K 24'h00_2000
`define SFE_SZ_16K 24'h00_4000
`define SFE_SZ_32K 24'h00_8000
`define SFE_SZ_64K 24'h01_0000
`define SFE_SZ_128K 24'h02_0000
`define SFE_SZ_256K 24'h04_0000
`define SFE_SZ_PAGE 24'h00_0100
`define SFE_BITS_OP 20'h0_0008
`define SFE_BITS_ADDR 20'h0_0020
`define SFE_PROG_CYC 16'h0040
`define SFE_ERASE_CYC 16'h0100
`define SFE_STAT_CYC 16'h0020
`endif

// File: src/sfe_pkg.sv
package sfe_pkg;
   typedef enum logic [3:0] {
      aoNone, aoProgram, aoErase4k, aoErase32k, aoErase64k, aoEraseChip,
      aoWriteStatus, aoSuspend, aoResume
   } sfe_arr_op_type;
   typedef enum logic [1:0] {opIdle, opBusy, opSusp} sfe_op_state_type;
   typedef struct packed {
      logic valid;
      sfe_arr_op_type op;
      logic [23:0] addr;
   } sfe_arr_cmd_type;
   typedef struct packed {
      logic valid;
      logic [7:0] data;
   } sfe_byte_type;
endpackage

// File: verif/sfe_front_end_sva.sv
`timescale 1ns/1ps
module sfe_front_end_sva import sfe_pkg::*; (
   input wire logic clk_sys, // Clock.
   input wire logic rstn, // Reset, low.
   input wire logic csN, // Select, low.
   input wire logic lane1Oe, // Drive enable.
   input sfe_arr_cmd_type arrCmd, // Command.
   input sfe_byte_type pageByte, // Page byte.
   input wire logic [15:0] statusWord, // Status.
   input wire logic busy // Busy.
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rstn);
   property p_oe_idle; csN |-> !lane1Oe; endproperty
   a_oe_idle: assert property (p_oe_idle) else $error("lane 1 driven while idle");
   property p_cmd_frame; arrCmd.valid |-> csN && $past(csN) && $past(csN, 2); endproperty
   a_cmd_frame: assert property (p_cmd_frame) else $error("command inside a frame");
   property p_cmd_pulse; arrCmd.valid |=> !arrCmd.valid; endproperty
   a_cmd_pulse: assert property (p_cmd_pulse) else $error("command held");
   property p_busy_start;
      arrCmd.valid && arrCmd.op inside {aoErase4k, aoErase32k, aoErase64k, aoProgram} |=> busy;
   endproperty
   a_busy_start: assert property (p_busy_start) else $error("no busy after command");
   property p_wel_clear; $fell(busy) && !statusWord[15] |-> ##[0:2] !statusWord[1]; endproperty
   a_wel_clear: assert property (p_wel_clear) else $error("latch kept after cycle");
   property p_align; arrCmd.valid && arrCmd.op == aoErase4k |-> arrCmd.addr[11:0] == 12'h000;
   endproperty
   a_align: assert property (p_align) else $error("sector address unaligned");
   property p_range; arrCmd.valid |-> arrCmd.addr < 24'h08_0000; endproperty
   a_range: assert property (p_range) else $error("address beyond array");
   property p_page_idle; pageByte.valid |-> !busy && statusWord[1]; endproperty
   a_page_idle: assert property (p_page_idle) else $error("page byte while busy");
endmodule
bind sfe_front_end sfe_front_end_sva sfe_front_end_sva_i (.clk_sys(clk_sys), .rstn(rstn),
   .csN(csN), .lane1Oe(lane1Oe), .arrCmd(arrCmd), .pageByte(pageByte),
   .statusWord(statusWord), .busy(busy));

// File: verif/sfe_front_end_test.sv
`timescale 1ns/1ps
module sfe_front_end_test import sfe_pkg::*;;
   localparam logic [7:0] MFR = 8'h6E; // Arbitrary value.
   localparam logic [7:0] DEV = 8'hC1; // Arbitrary value.
   localparam logic [15:0] LID = 16'h2B94; // Arbitrary value.
   logic clk_sys, rstn, spiClk, csN, lane0In, lane1In, lane2In, lane3In, lane1Out, lane1Oe, busy;
   sfe_arr_cmd_type arrCmd;
   sfe_byte_type pageByte;
   logic [15:0] statusWord;
   logic [63:0] rx;
   logic [27:0] expQ[$];
   logic [27:0] got;
   logic [23:0] ad;
   logic [7:0] d0, d1;
   int fail_count, checks_done, cycles = 0;
   logic [7:0] idOp [4] = '{8'hAB, 8'h90, 8'h92, 8'h94};
   logic [7:0] eOp [3] = '{8'h20, 8'h52, 8'hD8};
   logic [3:0] eTy [3] = '{4'(aoErase4k), 4'(aoErase32k), 4'(aoErase64k)};
   logic [23:0] eMask [3] = '{24'hFF_F000, 24'hFF_8000, 24'hFF_0000};
   logic [15:0] pSt [4] = '{16'h4000, 16'h4044, 16'h4044, 16'h401C};
   logic [7:0] pOp [4] = '{8'h20, 8'h20, 8'h20, 8'hD8};
   logic [23:0] pAd [4] = '{24'h03_0000, 24'h07_F000, 24'h07_E000, 24'h00_0000};
   logic [3:0] pOk = 4'b1010;
   sfe_front_end #(.MFR_ID(MFR), .DEV_ID(DEV), .LONG_ID(LID), .PROG_CYCLES(16'h0028),
      .ERASE_CYCLES(16'h05DC), .STAT_CYCLES(16'h0014)) sfe_front_end_i (.clk_sys(clk_sys),
      .rstn(rstn), .spiClk(spiClk), .csN(csN), .lane0In(lane0In), .lane1In(lane1In),
      .lane1Out(lane1Out), .lane1Oe(lane1Oe), .lane2In(lane2In), .lane3In(lane3In),
      .arrCmd(arrCmd), .pageByte(pageByte), .statusWord(statusWord), .busy(busy));
   sfe_host_model sfe_host_model_i (.spiClk(spiClk), .csN(csN), .lane0In(lane0In),
      .lane1In(lane1In), .lane2In(lane2In), .lane3In(lane3In), .lane1Out(lane1Out),
      .lane1Oe(lane1Oe));
   task automatic check(input logic [31:0] exp, input logic [31:0] act);
      checks_done = checks_done + 1;
      if (act !== exp) begin
         fail_count = fail_count + 1;
         $display("ERROR t=%0t exp=%h got=%h", $time, exp, act);
      end
   endtask
   task automatic summarize();
      $display("checks_done=%0d fail_count=%0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   task automatic xf(input int n, input int q, input logic [63:0] tx);
      sfe_host_model_i.frame(n, q, tx, rx);
   endtask
   task automatic waitIdle();
      for (int n = 0; n < 4000 && busy !== 1'b0; n++) @(negedge clk_sys);
      repeat (4) @(negedge clk_sys);
      check(32'h0, 32'(busy));
   endtask
   // Enable first, so any refusal that follows belongs to the frame itself.
   task automatic wr(input logic [63:0] tx, input int n, input logic [27:0] note, input bit take);
      xf(8, 0, {8'h06, 56'h0});
      if (take) expQ.push_back(note);
      xf(n, 0, tx);
      waitIdle();
   endtask
   task automatic endTest(input string name);
      repeat (8) @(negedge clk_sys);
      check(32'h0, 32'(expQ.size()));
      $display("test %s done", name);
   endtask
   always @(negedge clk_sys) begin
      if (arrCmd.valid === 1'b1 || pageByte.valid === 1'b1) begin
         got = arrCmd.valid === 1'b1 ? {4'(arrCmd.op), arrCmd.addr} : {20'hF_0000, pageByte.data};
         if (arrCmd.valid === 1'b1 && arrCmd.op >= aoWriteStatus) got[23:0] = 24'h0;
         if (expQ.size() == 0) check(32'h0, 32'(got));
         else check(32'(expQ.pop_front()), 32'(got));
      end
   end
   always @(posedge clk_sys) begin
      cycles <= cycles + 1;
      if (cycles == 60000) begin
         fail_count = fail_count + 1;
         summarize();
      end
   end
   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end
   initial begin
      fail_count = 0;
      checks_done = 0;
      rstn = 1'b0;
      void'($urandom(85895));
      repeat (16) @(negedge clk_sys);
      rstn = 1'b1;
      repeat (8) @(negedge clk_sys);
      check(32'h0, 32'(statusWord));
      xf(40, 0, {8'h9F, 56'h0});
      check({8'h0, MFR, LID}, 32'(rx[31:8]));
      for (int i = 0; i < 4; i++) begin
         xf(48, 0, {idOp[i], 56'h0});
         check(i == 0 ? {16'h0, DEV, DEV} : {16'h0, MFR, DEV}, 32'(rx[15:0]));
      end
      endTest("ident");
      xf(13, 0, {8'h05, 56'h0});
      xf(24, 0, {8'h05, 56'h0});
      check(32'h0, 32'(rx[15:0]));
      xf(8, 0, {8'h06, 56'h0});
      xf(24, 0, {8'h05, 56'h0});
      check(32'h0202, 32'(rx[15:0]));
      xf(24, 0, {8'h35, 56'h0});
      check(32'h0, 32'(rx[15:0]));
      xf(8, 0, {8'h00, 56'h0});
      xf(16, 0, {16'hFFFF, 48'h0});
      check(32'h0002, 32'(statusWord));
      wr({8'h20, 24'h01_0000, 32'h0}, 31, 28'h0, 1'b0);
      endTest("frame");
      for (int i = 0; i < 3; i++) begin
         ad = 24'($urandom) & 24'h07_FFFF;
         wr({eOp[i], ad, 32'h0}, 32, {eTy[i], ad & eMask[i]}, 1'b1);
         check(32'h0, 32'(statusWord));
      end
      endTest("erase");
      ad = 24'($urandom) & 24'h07_F000;
      xf(8, 0, {8'h06, 56'h0});
      expQ.push_back({4'(aoErase4k), ad});
      xf(32, 0, {8'h20, ad, 32'h0});
      xf(24, 0, {8'h05, 56'h0});
      check(32'h0303, 32'(rx[15:0]));
      xf(24, 0, {8'h9F, 56'h0});
      check(32'h0, 32'(sfe_host_model_i.seen));
      expQ.push_back({4'(aoSuspend), 24'h0});
      xf(8, 0, {8'h75, 56'h0});
      check(32'h1, 32'(statusWord[15]));
      expQ.push_back({4'(aoResume), 24'h0});
      xf(8, 0, {8'h7A, 56'h0});
      check(32'h0, 32'(statusWord[15]));
      waitIdle();
      endTest("busy");
      for (int i = 0; i < 4; i++) begin
         wr({8'h01, pSt[i][7:0], pSt[i][15:8], 40'h0}, 24, {4'(aoWriteStatus), 24'h0},
            1'b0);
         check(32'(pSt[i]), 32'(statusWord));
         wr({pOp[i], pAd[i], 32'h0}, 32,
            {pOp[i] == 8'h20 ? 4'(aoErase4k) : 4'(aoErase64k), pAd[i]}, pOk[i]);
      end
      endTest("protect");
      wr({8'h01, 8'h00, 8'h02, 40'h0}, 24, {4'(aoWriteStatus), 24'h0}, 1'b0);
      ad = 24'($urandom) & 24'h07_FF00;
      d0 = 8'($urandom);
      d1 = 8'($urandom);
      xf(8, 0, {8'h06, 56'h0});
      expQ.push_back({20'hF_0000, d0});
      expQ.push_back({20'hF_0000, d1});
      expQ.push_back({4'(aoProgram), ad});
      xf(32, 4, {8'h32, ad, d0, d1, 16'h0});
      waitIdle();
      endTest("quad");
      summarize();
   end
endmodule

// File: verif/sfe_host_model.sv
`timescale 1ns/1ps
module sfe_host_model (
   output logic spiClk, // Serial clock.
   output logic csN, // Select, low.
   output logic lane0In, // Lane 0.
   output logic lane1In, // Lane 1.
   output logic lane2In, // Lane 2.
   output logic lane3In, // Lane 3.
   input wire logic lane1Out, // Device data.
   input wire logic lane1Oe // Device enable.
);
   logic seen;
   initial begin
      spiClk = 1'b0;
      csN = 1'b1;
      {lane3In, lane2In, lane1In, lane0In} = 4'h0;
   end
   task automatic frame(input int nBits, input int nQuad, input logic [63:0] tx,
                        output logic [63:0] rx);
      int k;
      k = 0;
      rx = '0;
      seen = 1'b0;
      // The odd delay walks the link phase against the system clock from frame to frame.
      #3;
      csN = 1'b0;
      for (int i = 0; i < nBits + nQuad; i++) begin
         if (i < nBits) begin
            lane0In = tx[63 - k];
            k = k + 1;
         end else begin
            {lane3In, lane2In, lane1In, lane0In} = tx[63 - k -: 4];
            k = k + 4;
         end
         #80;
         spiClk = 1'b1;
         // A released lane reads as its pull-up.
         rx = {rx[62:0], lane1Oe ? lane1Out : 1'b1};
         seen = seen | lane1Oe;
         #80;
         spiClk = 1'b0;
      end
      csN = 1'b1;
      // Inverted idle lanes keep stale data from passing for fresh.
      {lane3In, lane2In, lane1In, lane0In} = ~{lane3In, lane2In, lane1In, lane0In};
      #240;
   endtask
endmodule
